// ---- inc/pmi2c_defines.svh ----
`ifndef PMI2C_DEFINES_SVH
`define PMI2C_DEFINES_SVH

// ---------------------------------------------
// software register offsets (byte addresses)
// ---------------------------------------------
`define PMI2C_OFS_CMD        8'h00
`define PMI2C_OFS_STAT       8'h04
`define PMI2C_OFS_SADDR      8'h08
`define PMI2C_DATA_PAGE      3'h1
`define PMI2C_DATA_ENTRIES   8

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define PMI2C_CMD_PTR_MSB    4
`define PMI2C_CMD_RD_BIT     5
`define PMI2C_CMD_CNT_LSB    8
`define PMI2C_CMD_CNT_MSB    10
`define PMI2C_STAT_BUSY      0
`define PMI2C_STAT_DONE      1
`define PMI2C_STAT_NACK      2
`define PMI2C_STAT_FAULT     3

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define PMI2C_SADDR_RST      7'h00
`define PMI2C_PTR_RST        5'h00
`define PMI2C_CNT_RST        3'h0

// ---------------------------------------------
// device register map seen over the link
// ---------------------------------------------
`define PMI2C_REG_WD_KEY     5'h02
`define PMI2C_WD_KEY_OPEN    8'h5A
`define PMI2C_WD_KEY_RST     8'h00

// ---------------------------------------------
// timing: one quarter of a serial clock period
// ---------------------------------------------
`define PMI2C_CLK_MHZ        200
`define PMI2C_QUARTER_NS     250
`define PMI2C_QUARTER_CYC    ((`PMI2C_QUARTER_NS * `PMI2C_CLK_MHZ + 999) / 1000)

`endif

// ---- inc/pmi2c_pkg.sv ----
package pmi2c_pkg;

   typedef enum logic [3:0] {
      PMI2C_IDLE  = 4'h1,
      PMI2C_START = 4'h2,
      PMI2C_BIT   = 4'h4,
      PMI2C_STOP  = 4'h8
   } pmi2c_state_t;

   typedef enum logic [4:0] {
      PMI2C_ADDR_W = 5'h01,
      PMI2C_PTR    = 5'h02,
      PMI2C_WDATA  = 5'h04,
      PMI2C_ADDR_R = 5'h08,
      PMI2C_RDATA  = 5'h10
   } pmi2c_stage_t;

   typedef struct packed {
      logic [8:0] cnt;
      logic       tick;
   } pmi2c_tick_st_t;

   typedef struct packed {
      pmi2c_state_t    state;
      pmi2c_stage_t    stage;
      logic [1:0]      q;
      logic [3:0]      bitn;
      logic [7:0]      sh;
      logic [2:0]      idx;
      logic [2:0]      cnt;
      logic [4:0]      ptr;
      logic            rd;
      logic [6:0]      saddr;
      logic [7:0][7:0] mem;
      logic            nak;
      logic            busy;
      logic            done;
      logic            nack;
      logic            fault;
      logic            run;
      logic            scl;
      logic            sda_oe;
      logic            sda_o;
      logic            sel;
      logic            sda_s1;
      logic            sda_s2;
      logic [31:0]     rdata;
   } pmi2c_st_t;

endpackage

// ---- inc/pmi2c_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface pmi2c_tick_if;
   logic run;
   logic tick;
   modport src (input run, output tick);
   modport snk (output run, input tick);
endinterface

`default_nettype wire

// ---- logic/pmi2c_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmi2c_defines.svh"

module pmi2c_tick
   import pmi2c_pkg::*;
(
   // clock and reset
   input  wire logic     i_clk,
   input  wire logic     i_reset_n,
   // quarter-period enable
   pmi2c_tick_if.src     tk
);

   localparam logic [8:0] LAST = 9'(`PMI2C_QUARTER_CYC - 1);

   pmi2c_tick_st_t r;
   pmi2c_tick_st_t n;

   // ---------------------------------------------
   // divider: one pulse per quarter bit
   // ---------------------------------------------
   always_comb begin
      n = r;
      n.tick = 1'b0;
      if (!tk.run) begin
         n.cnt = 9'h000;
      end else if (r.cnt == LAST) begin
         n.cnt  = 9'h000;
         n.tick = 1'b1;
      end else begin
         n.cnt = r.cnt + 9'h001;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign tk.tick = r.tick;

endmodule

`default_nettype wire

// ---- logic/pmi2c_host.sv ----
// Overview of operation
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - only this master creates START and STOP; the device never does.
// - after START, SDA changes only while SCL is low.
// - ninth bit is acknowledge; transmitter releases SDA, receiver pulls it low.
// - receiver releases SDA when the low phase after the ninth clock begins; the host as receiver releases it one quarter bit later.
// - write: address with direction 0, then pointer with 3 zero bits, 5 select.
// - a write ends with STOP or repeated START after the last acknowledge.
// - read: write pointer, repeated START, address with direction bit one.
// - master acknowledge on clock 9 makes the device send the next register.
// - master withholds acknowledge on the last byte, then sends STOP.
// - static select input: high picks the two-wire port, low the SPI port.
//
// Chosen here: the two-wire port, with the select pin tied high.
`timescale 1ns/1ps
`default_nettype none
`include "pmi2c_defines.svh"

module pmi2c_host
   import pmi2c_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // software register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // two-wire link
   output logic             o_scl,
   input  wire logic        i_sda,
   output logic             o_sda_o,
   output logic             o_sda_oe,
   // port selection pin
   output logic             o_if_select
);

   pmi2c_st_t    r;
   pmi2c_st_t    n;
   pmi2c_tick_if tk ();

   // ---------------------------------------------
   // quarter-bit enable
   // ---------------------------------------------
   pmi2c_tick u_tick (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .tk        (tk)
   );

   assign tk.run = r.run;

   // ---------------------------------------------
   // next-state logic
   // ---------------------------------------------
   always_comb begin
      logic       tx;
      logic       last;
      logic [2:0] di;
      tx   = 1'b0;
      last = 1'b0;
      di   = 3'h0;
      n    = r;

      // input synchroniser on the data line
      n.sda_s1 = i_sda;
      n.sda_s2 = r.sda_s1;

      tx   = (r.stage != PMI2C_RDATA);
      last = (r.idx == r.cnt);
      di   = i_addr[4:2];

      // ---------------------------------------------
      // software reads: data one cycle later
      // ---------------------------------------------
      n.rdata = 32'h0000_0000;
      if (i_rd) begin
         if (i_addr == `PMI2C_OFS_CMD) begin
            n.rdata[`PMI2C_CMD_PTR_MSB:0] = r.ptr;
            n.rdata[`PMI2C_CMD_RD_BIT] = r.rd;
            n.rdata[`PMI2C_CMD_CNT_MSB:`PMI2C_CMD_CNT_LSB] = r.cnt;
         end else if (i_addr == `PMI2C_OFS_STAT) begin
            n.rdata[`PMI2C_STAT_BUSY]  = r.busy;
            n.rdata[`PMI2C_STAT_DONE]  = r.done;
            n.rdata[`PMI2C_STAT_NACK]  = r.nack;
            n.rdata[`PMI2C_STAT_FAULT] = r.fault;
         end else if (i_addr == `PMI2C_OFS_SADDR) begin
            n.rdata[6:0] = r.saddr;
         end else if (i_addr[7:5] == `PMI2C_DATA_PAGE && i_addr[1:0] == 2'h0) begin
            n.rdata[7:0] = r.mem[di];
         end
      end

      // ---------------------------------------------
      // software writes
      // ---------------------------------------------
      if (i_wr) begin
         if (i_addr == `PMI2C_OFS_STAT) begin
            // write one to clear; hardware sets below win
            if (i_wdata[`PMI2C_STAT_DONE]) begin
               n.done = 1'b0;
            end
            if (i_wdata[`PMI2C_STAT_NACK]) begin
               n.nack = 1'b0;
            end
            if (i_wdata[`PMI2C_STAT_FAULT]) begin
               n.fault = 1'b0;
            end
         end else if (!r.busy) begin
            if (i_addr == `PMI2C_OFS_SADDR) begin
               n.saddr = i_wdata[6:0];
            end else if (i_addr[7:5] == `PMI2C_DATA_PAGE && i_addr[1:0] == 2'h0) begin
               n.mem[di] = i_wdata[7:0];
            end else if (i_addr == `PMI2C_OFS_CMD) begin
               // command write launches a transfer
               n.ptr   = i_wdata[`PMI2C_CMD_PTR_MSB:0];
               n.rd    = i_wdata[`PMI2C_CMD_RD_BIT];
               n.cnt   = i_wdata[`PMI2C_CMD_CNT_MSB:`PMI2C_CMD_CNT_LSB];
               n.busy  = 1'b1;
               n.done  = 1'b0;
               n.nack  = 1'b0;
               n.fault = 1'b0;
               n.run   = 1'b1;
               n.state = PMI2C_START;
               n.stage = PMI2C_ADDR_W;
               n.q     = 2'h0;
               n.bitn  = 4'h0;
               n.idx   = 3'h0;
            end
         end
      end

      // ---------------------------------------------
      // link sequencer, one step per quarter bit
      // ---------------------------------------------
      if (tk.tick) begin
         n.q = r.q + 2'h1;
         unique case (r.state)
            PMI2C_IDLE: begin
               n.q = 2'h0;
            end
            PMI2C_START: begin
               unique case (r.q)
                  2'h0: begin
                     n.scl    = 1'b0;
                     n.sda_oe = 1'b0;
                  end
                  2'h1: begin
                     n.scl = 1'b1;
                  end
                  2'h2: begin
                     n.sda_oe = 1'b1;
                  end
                  2'h3: begin
                     n.scl  = 1'b0;
                     n.bitn = 4'h0;
                     n.state = PMI2C_BIT;
                     if (r.stage == PMI2C_ADDR_R) begin
                        n.sh = {r.saddr, 1'b1};
                     end else begin
                        n.sh = {r.saddr, 1'b0};
                     end
                  end
               endcase
            end
            PMI2C_BIT: begin
               unique case (r.q)
                  2'h0: begin
                     n.scl = 1'b0;
                     if (r.bitn < 4'h8) begin
                        n.sda_oe = tx & ~r.sh[7];
                     end else begin
                        n.sda_oe = ~tx & ~last;
                     end
                  end
                  2'h1: begin
                     n.scl = 1'b1;
                  end
                  2'h2: begin
                     if (r.bitn < 4'h8) begin
                        if (!tx) begin
                           n.sh = {r.sh[6:0], r.sda_s2};
                        end else if (!r.sh[7] != !r.sda_s2 && r.sh[7]) begin
                           n.fault = 1'b1;
                        end
                     end else begin
                        n.nak = r.sda_s2;
                     end
                  end
                  2'h3: begin
                     n.scl = 1'b0;
                     if (r.bitn < 4'h8) begin
                        n.bitn = r.bitn + 4'h1;
                        if (tx) begin
                           n.sh = {r.sh[6:0], 1'b0};
                        end
                     end else begin
                        n.bitn = 4'h0;
                        if (tx && r.nak) begin
                           n.nack   = 1'b1;
                           n.sda_oe = 1'b0;
                           n.state  = PMI2C_STOP;
                        end else begin
                           unique case (r.stage)
                              PMI2C_ADDR_W: begin
                                 n.stage = PMI2C_PTR;
                                 n.sh    = {3'b000, r.ptr};
                              end
                              PMI2C_PTR: begin
                                 if (r.rd) begin
                                    n.stage = PMI2C_ADDR_R;
                                    n.state = PMI2C_START;
                                 end else begin
                                    n.stage = PMI2C_WDATA;
                                    n.sh    = r.mem[3'h0];
                                 end
                              end
                              PMI2C_WDATA: begin
                                 if (last) begin
                                    n.state = PMI2C_STOP;
                                 end else begin
                                    n.idx = r.idx + 3'h1;
                                    n.sh  = r.mem[r.idx + 3'h1];
                                 end
                              end
                              PMI2C_ADDR_R: begin
                                 n.stage = PMI2C_RDATA;
                                 n.sh    = 8'h00;
                              end
                              PMI2C_RDATA: begin
                                 n.mem[r.idx] = r.sh;
                                 if (last) begin
                                    n.state = PMI2C_STOP;
                                 end else begin
                                    n.idx = r.idx + 3'h1;
                                 end
                              end
                              default: begin
                                 n.state = PMI2C_STOP;
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
            PMI2C_STOP: begin
               unique case (r.q)
                  2'h0: begin
                     n.scl    = 1'b0;
                     n.sda_oe = 1'b1;
                  end
                  2'h1: begin
                     n.scl = 1'b1;
                  end
                  2'h2: begin
                     n.sda_oe = 1'b0;
                  end
                  2'h3: begin
                     n.state = PMI2C_IDLE;
                     n.busy  = 1'b0;
                     n.done  = 1'b1;
                     n.run   = 1'b0;
                  end
               endcase
            end
            default: begin
               n.state  = PMI2C_IDLE;
               n.scl    = 1'b1;
               n.sda_oe = 1'b0;
               n.busy   = 1'b0;
               n.run    = 1'b0;
            end
         endcase
      end

      // select pin is static, data line only ever pulled low
      n.sel   = 1'b1;
      n.sda_o = 1'b0;
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r        <= '0;
         r.state  <= PMI2C_IDLE;
         r.stage  <= PMI2C_ADDR_W;
         r.saddr  <= `PMI2C_SADDR_RST;
         r.ptr    <= `PMI2C_PTR_RST;
         r.cnt    <= `PMI2C_CNT_RST;
         r.scl    <= 1'b1;
         r.sel    <= 1'b1;
         r.sda_s1 <= 1'b1;
         r.sda_s2 <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign o_rdata     = r.rdata;
   assign o_scl       = r.scl;
   assign o_sda_o     = r.sda_o;
   assign o_sda_oe    = r.sda_oe;
   assign o_if_select = r.sel;

endmodule

`default_nettype wire

// ---- testbench/pmi2c_host_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmi2c_defines.svh"

module pmi2c_host_asserts (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // software register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [31:0] o_rdata,
   // two-wire link
   input  wire logic        o_scl,
   input  wire logic        i_sda,
   input  wire logic        o_sda_o,
   input  wire logic        o_sda_oe,
   input  wire logic        o_if_select
);
   logic [9:0] hi_cnt;

   // cycles of clock high, saturating; idle counts as long high
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hi_cnt <= 10'h3FF;
      end else if (!o_scl) begin
         hi_cnt <= 10'h000;
      end else if (hi_cnt != 10'h3FF) begin
         hi_cnt <= hi_cnt + 10'h001;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_data_stable_high: assert property (o_scl && $past(o_scl) && hi_cnt < 10'h028 |-> $stable(o_sda_oe))
      else $error("data line moved early in clock high");
   a_open_drain_low: assert property (o_sda_o == 1'b0)
      else $error("data line driven high");
   a_port_select_high: assert property (o_if_select == 1'b1)
      else $error("port select not high");
   a_start_then_low: assert property ($rose(o_sda_oe) && o_scl |-> ##[1:600] !o_scl)
      else $error("no clock low after start");
   a_stop_holds_high: assert property ($fell(o_sda_oe) && o_scl |-> o_scl [*8])
      else $error("clock dropped after stop");
   a_clock_high_time: assert property ($fell(o_scl) |-> hi_cnt >= 10'h060)
      else $error("clock high phase too short");
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   a_cmd_starts_link: assert property (i_wr && i_addr == `PMI2C_OFS_CMD && hi_cnt == 10'h3FF
      && !o_sda_oe |-> ##[1:200] !o_scl)
      else $error("command did not start link");
endmodule

bind pmi2c_host pmi2c_host_asserts u_asserts (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_scl(o_scl), .i_sda(i_sda),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_if_select(o_if_select)
);

`default_nettype wire

// ---- testbench/pmi2c_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pmi2c_dev_model #(
   parameter logic [6:0] DEV_ADDR   = 7'h2A,
   parameter logic [4:0] WD_CFG_OFS = 5'h03
) (
   // two-wire link
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda_pull
);
   logic [7:0] regs [32];
   logic [7:0] sh;
   logic [7:0] tx;
   logic [4:0] ptr;
   logic       act;
   logic       rdm;
   logic       mack;
   int         bitc;
   int         ph;

   // reserved places read zero
   function automatic logic [7:0] rd_reg(input logic [4:0] a);
      return (a < 5'h02) ? 8'h00 : regs[a];
   endfunction

   initial begin
      foreach (regs[k]) regs[k] = 8'h00; // key resets closed
      o_sda_pull = 1'b0;
      act = 1'b0;
      rdm = 1'b0;
      ptr = 5'h00;
   end

   always @(negedge i_sda) if (i_scl === 1'b1) begin
      act = 1'b1;
      rdm = 1'b0;
      ph = 0;
      bitc = -1;
      o_sda_pull = 1'b0;
   end

   always @(posedge i_sda) if (i_scl === 1'b1) begin
      act = 1'b0;
      o_sda_pull = 1'b0;
   end

   always @(posedge i_scl) if (act) begin
      if (bitc < 8) sh = {sh[6:0], i_sda};
      else mack = !i_sda;
   end

   always @(negedge i_scl) if (act) begin
      if (bitc == 7) begin
         bitc = 8;
         o_sda_pull = 1'b0;
         if (ph == 0) begin
            if (sh[7:1] == DEV_ADDR) begin
               o_sda_pull = 1'b1;
               rdm = sh[0];
            end else begin
               act = 1'b0;
            end
         end else if (!rdm) begin
            o_sda_pull = 1'b1;
            if (ph == 1) begin
               ptr = sh[4:0];
            end else begin
               if (ptr >= 5'h02 && (ptr != WD_CFG_OFS || regs[2] == 8'h5A)) regs[ptr] = sh;
               ptr = ptr + 5'h01;
            end
         end
      end else if (bitc == 8) begin
         bitc = 0;
         o_sda_pull = 1'b0;
         if (rdm && (ph == 0 || mack)) begin
            if (ph != 0) ptr = ptr + 5'h01;
            ph = 2;
            tx = rd_reg(ptr);
            o_sda_pull = !tx[7];
         end else if (rdm) begin
            act = 1'b0;
         end else if (ph < 2) begin
            ph = ph + 1;
         end
      end else begin
         bitc = bitc + 1;
         if (rdm && ph == 2) begin
            tx = tx << 1;
            o_sda_pull = !tx[7];
         end
      end
   end
endmodule

`default_nettype wire

// ---- testbench/pmi2c_host_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmi2c_defines.svh"

module pmi2c_host_tb_top;
   logic        i_clk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_scl;
   logic        o_sda_o;
   logic        o_sda_oe;
   logic        o_if_select;
   logic        dev_pull;
   wire logic   sda_line;
   logic [31:0] rv;
   logic [7:0]  exp_rd [5] = '{8'h3C, 8'h00, 8'h00, 8'h5A, 8'h81};
   int          bad_count = 0;
   int          tests_run = 0;
   int          cyc = 0;

   always #2.5 i_clk = ~i_clk;
   // open-drain line with pull-up
   assign sda_line = (o_sda_oe | dev_pull) ? 1'b0 : 1'b1;

   pmi2c_host uut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_scl(o_scl), .i_sda(sda_line),
      .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_if_select(o_if_select)
   );

   pmi2c_dev_model dev (.i_scl(o_scl), .i_sda(sda_line), .o_sda_pull(dev_pull));

   // ------------------------------------------
   // shared tasks
   // ------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic wait_done();
      rv = 32'h0000_0001;
      while (rv[`PMI2C_STAT_BUSY] !== 1'b0) reg_rd(`PMI2C_OFS_STAT, rv);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic t_reset();
      reg_rd(`PMI2C_OFS_STAT, rv);
      check(rv, 32'h0, "status after reset");
      reg_rd(`PMI2C_OFS_SADDR, rv);
      check(rv, 32'h0, "address after reset");
      reg_rd(8'h40, rv);
      check(rv, 32'h0, "unmapped read");
      check({31'h0, o_if_select}, 32'h1, "port select");
      check({31'h0, o_scl}, 32'h1, "clock idle");
      check({24'h0, dev.regs[2]}, 32'h0, "key reset");
   endtask

   // five bytes from the last place: wrap, reserved, key, then guarded place
   task automatic t_write();
      reg_wr(`PMI2C_OFS_SADDR, 32'h2A);
      reg_wr(8'h20, 32'h3C);
      reg_wr(8'h24, 32'hC3);
      reg_wr(8'h28, 32'h7E);
      reg_wr(8'h2C, 32'h5A);
      reg_wr(8'h30, 32'h81);
      reg_wr(`PMI2C_OFS_CMD, 32'h0000_041F);
      wait_done();
      check(rv, 32'h2, "write status");
      check({24'h0, dev.regs[5'h1F]}, 32'h3C, "last place");
      check({24'h0, dev.regs[0]}, 32'h0, "reserved 0");
      check({24'h0, dev.regs[1]}, 32'h0, "reserved 1");
      check({24'h0, dev.regs[2]}, 32'h5A, "key place");
      check({24'h0, dev.regs[3]}, 32'h81, "guarded place");
      reg_wr(`PMI2C_OFS_STAT, 32'hE);
      reg_rd(`PMI2C_OFS_STAT, rv);
      check(rv, 32'h0, "status cleared");
   endtask

   task automatic t_read();
      for (int i = 0; i < 5; i++) reg_wr(8'h20 + 8'(i * 4), 32'hFF);
      reg_wr(`PMI2C_OFS_CMD, 32'h0000_043F);
      wait_done();
      check(rv, 32'h2, "read status");
      for (int i = 0; i < 5; i++) begin
         reg_rd(8'h20 + 8'(i * 4), rv);
         check(rv, {24'h0, exp_rd[i]}, "read byte");
      end
   endtask

   // foreign address; address change while busy is refused
   task automatic t_foreign();
      reg_wr(`PMI2C_OFS_SADDR, 32'h15);
      reg_wr(8'h20, 32'h99);
      reg_wr(`PMI2C_OFS_CMD, 32'h0000_0005);
      reg_wr(`PMI2C_OFS_SADDR, 32'h2A);
      wait_done();
      check(rv, 32'h6, "foreign status");
      check({24'h0, dev.regs[5]}, 32'h0, "foreign untouched");
      reg_rd(`PMI2C_OFS_SADDR, rv);
      check(rv, 32'h15, "address kept while busy");
   endtask

   // ------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------
   initial begin
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_foreign();
      print_verdict();
   end

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         $display("MISMATCH at %0t: run did not finish", $time);
         print_verdict();
      end
   end
endmodule

`default_nettype wire
